// *** core/ppmc_phy_power_mode_control.sv ***
// Power-mode controller with management registers and standby logic.
module ppmc_phy_power_mode_control #(
  parameter int LP_NORMAL_CYCLES = ppmc_pkg::LP_NORMAL_CYC,
  parameter int LP_ENERGY_IDLE_POWERDOWN_CYCLES   = ppmc_pkg::LP_ENERGY_IDLE_POWERDOWN_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic        core_supply_ok_i,
  input  wire logic        link_up_i,
  input  wire logic        energy_pair_a_i,
  input  wire logic        energy_pair_b_i,
  output logic             cable_energy_indicator_o,
  output logic             standby_o,
  output logic             core_func_en_o,
  output logic             rx_blocks_en_o,
  output logic             pll_en_o,
  output logic             tx_en_o,
  output logic             energy_det_en_o,
  output logic             io_en_o,
  output logic             slow_osc_sel_o,
  output logic             link_pulse_o,
  output logic             soft_reset_o
);

  ppmc_reg_if bus ();

  logic        autoneg_r;
  logic        pdown_r;
  logic        sreset_r;
  logic        ps_en_r;
  logic        energy_idle_powerdown_dis_r;
  logic        pll_off_r;
  logic        slow_osc_r;
  logic [15:0] ac2_r;
  logic [15:0] stby_r;
  logic [15:0] nv_ac2_r;
  logic [15:0] nv_stby_r;
  logic        ind_r;
  logic [11:0] dly_cnt_r;
  logic        standby_r;
  logic [31:0] lp_cnt_r;
  logic        wr;
  logic        vol_clr;
  logic        no_link;
  logic        ps_act;
  logic        energy_idle_powerdown_act;
  logic        alive;
  logic        stby_en;
  logic        energy;
  logic [11:0] dly_last;
  logic [31:0] lp_last;

  ppmc_mdio_slave u_mdio (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .mdc_i     (mdc_i),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o),
    .phy_addr_i(phy_addr_i),
    .bus       (bus.master)
  );

  // Management stays up in power-down but not in standby or without core.
  assign bus.enable = ~standby_r & core_supply_ok_i;
  assign wr         = bus.wr_stb & bus.enable;
  // Core supply loss or a software reset drop the volatile bits.
  assign vol_clr    = ~core_supply_ok_i | sreset_r;

  // Basic control: self-clearing soft reset, autoneg, power-down.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      autoneg_r <= ppmc_pkg::BC_AUTONEG_RST;
      pdown_r   <= 1'b0;
      sreset_r  <= 1'b0;
    end else if (vol_clr) begin
      autoneg_r <= ppmc_pkg::BC_AUTONEG_RST;
      pdown_r   <= 1'b0;
      sreset_r  <= 1'b0;
    end else if (wr && bus.addr == ppmc_pkg::REG_BASIC_CTRL) begin
      autoneg_r <= bus.wdata[ppmc_pkg::BC_AUTONEG_EN];
      pdown_r   <= bus.wdata[ppmc_pkg::BC_POWER_DOWN];
      sreset_r  <= bus.wdata[ppmc_pkg::BC_SOFT_RESET];
    end
  end

  // Mode bits kept in the core; both low-power modes start disabled.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || vol_clr) begin
      ps_en_r    <= 1'b0;
      energy_idle_powerdown_dis_r <= ppmc_pkg::EC_ENERGY_IDLE_POWERDOWN_DIS_RST;
      pll_off_r  <= 1'b0;
      slow_osc_r <= 1'b0;
    end else if (wr) begin
      case (bus.addr)
        ppmc_pkg::REG_PHY_CTRL2:
          ps_en_r <= bus.wdata[ppmc_pkg::PC2_POWER_SAVE];
        ppmc_pkg::REG_EXP_CTRL:
          energy_idle_powerdown_dis_r <= bus.wdata[ppmc_pkg::EC_ENERGY_IDLE_POWERDOWN_DISABLE];
        ppmc_pkg::REG_DIG_CTRL:
          pll_off_r <= bus.wdata[ppmc_pkg::DC_PLL_OFF];
        ppmc_pkg::REG_AFE_CTRL0:
          slow_osc_r <= bus.wdata[ppmc_pkg::AC0_SLOW_OSC];
        default: ;
      endcase
    end
  end

  // Volatile 13h/14h; without core supply they mirror the retained copy,
  // so the values come back from the always-on block at power return.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      stby_r <= ppmc_pkg::STBY_RST;
      ac2_r  <= ppmc_pkg::AC2_RST;
    end else if (!core_supply_ok_i) begin
      stby_r <= nv_stby_r;
      ac2_r  <= nv_ac2_r;
    end else if (sreset_r) begin
      stby_r <= ppmc_pkg::STBY_RST;
      ac2_r  <= ppmc_pkg::AC2_RST;
    end else if (wr && bus.addr == ppmc_pkg::REG_STBY_CTRL) begin
      stby_r <= bus.wdata & ppmc_pkg::STBY_MASK;
    end else if (wr && bus.addr == ppmc_pkg::REG_AFE_CTRL2) begin
      ac2_r  <= bus.wdata & ppmc_pkg::AC2_KEEP_MASK;
    end
  end

  // Always-on copies; only hardware reset clears them.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      nv_stby_r <= ppmc_pkg::STBY_RST;
      nv_ac2_r  <= ppmc_pkg::AC2_RST;
    end else if (wr) begin
      if (bus.addr == ppmc_pkg::REG_STBY_CTRL &&
          bus.wdata[ppmc_pkg::SC_RETAIN_ACCESS]) begin
        nv_stby_r <= bus.wdata & ppmc_pkg::STBY_MASK;
      end
      if (bus.addr == ppmc_pkg::REG_AFE_CTRL2 &&
          stby_r[ppmc_pkg::SC_RETAIN_ACCESS]) begin
        nv_ac2_r <= bus.wdata & ppmc_pkg::AC2_KEEP_MASK;
      end
    end
  end

  // Read-back; unimplemented bits and addresses read zero.
  always_comb begin
    bus.rdata = 16'h0000;
    case (bus.addr)
      ppmc_pkg::REG_BASIC_CTRL: begin
        bus.rdata[ppmc_pkg::BC_SOFT_RESET] = sreset_r;
        bus.rdata[ppmc_pkg::BC_AUTONEG_EN] = autoneg_r;
        bus.rdata[ppmc_pkg::BC_POWER_DOWN] = pdown_r;
      end
      ppmc_pkg::REG_BASIC_STAT:
        bus.rdata[ppmc_pkg::BS_LINK_UP] = link_up_i;
      ppmc_pkg::REG_DIG_CTRL:
        bus.rdata[ppmc_pkg::DC_PLL_OFF] = pll_off_r;
      ppmc_pkg::REG_AFE_CTRL0:
        bus.rdata[ppmc_pkg::AC0_SLOW_OSC] = slow_osc_r;
      ppmc_pkg::REG_AFE_CTRL2:
        bus.rdata = ac2_r;
      ppmc_pkg::REG_STBY_CTRL:
        bus.rdata = stby_r;
      ppmc_pkg::REG_EXP_CTRL:
        bus.rdata[ppmc_pkg::EC_ENERGY_IDLE_POWERDOWN_DISABLE] = energy_idle_powerdown_dis_r;
      ppmc_pkg::REG_PHY_CTRL2:
        bus.rdata[ppmc_pkg::PC2_POWER_SAVE] = ps_en_r;
      default:
        bus.rdata = 16'h0000;
    endcase
  end

  assign stby_en  = stby_r[ppmc_pkg::SC_STANDBY_EN];
  assign energy   = energy_pair_a_i | energy_pair_b_i;
  assign dly_last = stby_r[ppmc_pkg::SC_LONG_DEASSERT] ?
                    12'(ppmc_pkg::DEASSERT_LONG_CYC - 1) :
                    12'(ppmc_pkg::DEASSERT_SHORT_CYC - 1);

  // Indicator asserts at once on energy and drops after a quiet delay;
  // the delay filters short gaps between link pulses.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ind_r     <= 1'b1;
      dly_cnt_r <= 12'h000;
    end else if (!stby_en || energy) begin
      ind_r     <= 1'b1;
      dly_cnt_r <= 12'h000;
    end else if (dly_cnt_r >= dly_last) begin
      ind_r     <= 1'b0;
    end else begin
      dly_cnt_r <= dly_cnt_r + 12'h001;
    end
  end

  // Indicator pin; the host relies on it staying high through bring-up.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cable_energy_indicator_o <= 1'b1;
    end else if (!stby_en) begin
      cable_energy_indicator_o <= 1'b1;
    end else begin
      cable_energy_indicator_o <= ind_r ^ stby_r[ppmc_pkg::SC_POLARITY];
    end
  end

  // Standby latches; nothing but hardware reset releases it.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      standby_r <= 1'b0;
    end else if (stby_en) begin
      if (!stby_r[ppmc_pkg::SC_ENTRY_CPU] && !ind_r) begin
        standby_r <= 1'b1;
      end else if (stby_r[ppmc_pkg::SC_ENTRY_CPU] &&
                   stby_r[ppmc_pkg::SC_SLEEP_NOW]) begin
        standby_r <= 1'b1;
      end
    end
  end

  assign no_link  = autoneg_r & ~link_up_i;
  assign ps_act   = ps_en_r & no_link;
  assign energy_idle_powerdown_act = ~energy_idle_powerdown_dis_r & no_link;
  assign alive    = ~standby_r & ~pdown_r;

  // Block enables, registered so they never glitch into analog control.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      standby_o       <= 1'b0;
      core_func_en_o  <= 1'b1;
      rx_blocks_en_o  <= 1'b1;
      pll_en_o        <= 1'b1;
      tx_en_o         <= 1'b1;
      energy_det_en_o <= 1'b1;
      io_en_o         <= 1'b1;
      slow_osc_sel_o  <= 1'b0;
      soft_reset_o    <= 1'b0;
    end else begin
      standby_o       <= standby_r;
      core_func_en_o  <= alive;
      rx_blocks_en_o  <= alive & ~ps_act & ~energy_idle_powerdown_act;
      pll_en_o        <= alive & ~(energy_idle_powerdown_act & pll_off_r);
      tx_en_o         <= alive;
      energy_det_en_o <= alive;
      io_en_o         <= ~standby_r;
      slow_osc_sel_o  <= slow_osc_r;
      soft_reset_o    <= sreset_r;
    end
  end

  assign lp_last = energy_idle_powerdown_act ? 32'(LP_ENERGY_IDLE_POWERDOWN_CYCLES - 1) :
                              32'(LP_NORMAL_CYCLES - 1);

  // Link pulse timer, running only while the transmitter is up unlinked.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !alive || link_up_i) begin
      lp_cnt_r     <= 32'h00000000;
      link_pulse_o <= 1'b0;
    end else if (lp_cnt_r >= lp_last) begin
      lp_cnt_r     <= 32'h00000000;
      link_pulse_o <= 1'b1;
    end else begin
      lp_cnt_r     <= lp_cnt_r + 32'h00000001;
      link_pulse_o <= 1'b0;
    end
  end

endmodule // ppmc_phy_power_mode_control

// *** include/ppmc_pkg.sv ***
// Shared constants and types of the PHY power-mode controller.
package ppmc_pkg;

  // Management register addresses.
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_BASIC_STAT = 5'h01;
  localparam logic [4:0] REG_DIG_CTRL   = 5'h10;
  localparam logic [4:0] REG_AFE_CTRL0  = 5'h11;
  localparam logic [4:0] REG_AFE_CTRL2  = 5'h13;
  localparam logic [4:0] REG_STBY_CTRL  = 5'h14;
  localparam logic [4:0] REG_EXP_CTRL   = 5'h18;
  localparam logic [4:0] REG_PHY_CTRL2  = 5'h1f;

  // Field positions.
  localparam int BC_SOFT_RESET     = 15;
  localparam int BC_AUTONEG_EN     = 12;
  localparam int BC_POWER_DOWN     = 11;
  localparam int BS_LINK_UP        = 2;
  localparam int DC_PLL_OFF        = 4;
  localparam int AC0_SLOW_OSC      = 6;
  localparam int SC_ENTRY_CPU      = 6;
  localparam int SC_SLEEP_NOW      = 5;
  localparam int SC_RETAIN_ACCESS  = 4;
  localparam int SC_STANDBY_EN     = 3;
  localparam int SC_LONG_DEASSERT  = 1;
  localparam int SC_POLARITY       = 0;
  localparam int EC_ENERGY_IDLE_POWERDOWN_DISABLE   = 11;
  localparam int PC2_POWER_SAVE    = 10;

  // Implemented bits of the retained registers.
  localparam logic [15:0] AC2_KEEP_MASK  = 16'h0303;
  localparam logic [15:0] STBY_MASK      = 16'h007b;

  // Values after reset.
  localparam logic       BC_AUTONEG_RST = 1'h1;
  localparam logic       EC_ENERGY_IDLE_POWERDOWN_DIS_RST = 1'h1;
  localparam logic [15:0] STBY_RST      = 16'h0000;
  localparam logic [15:0] AC2_RST       = 16'h0000;

  // Timing of the cable-energy indicator and of link pulses.
  localparam int CLK_PERIOD_NS      = 20;
  localparam int DEASSERT_SHORT_NS  = 10000;
  localparam int DEASSERT_LONG_NS   = 80000;
  localparam int DEASSERT_SHORT_CYC =
    (DEASSERT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEASSERT_LONG_CYC  =
    (DEASSERT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_NORMAL_NS       = 16000000;
  localparam int LP_ENERGY_IDLE_POWERDOWN_NS         = 256000000;
  localparam int LP_NORMAL_CYC      = LP_NORMAL_NS / CLK_PERIOD_NS;
  localparam int LP_ENERGY_IDLE_POWERDOWN_CYC        = LP_ENERGY_IDLE_POWERDOWN_NS / CLK_PERIOD_NS;

  // Serial management frame.
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_LAST     = 6'h0b;
  localparam logic [5:0] RD_LAST      = 6'h11;
  localparam logic [5:0] WR_FIRST     = 6'h02;
  localparam logic [5:0] WR_LAST      = 6'h11;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;

  typedef enum logic [4:0] {
    MS_IDLE  = 5'b00001,
    MS_START = 5'b00010,
    MS_HDR   = 5'b00100,
    MS_READ  = 5'b01000,
    MS_WRITE = 5'b10000
  } ppmc_mdio_state_t;

endpackage

// *** include/ppmc_reg_if.sv ***
// Register access carrier between the management slave and the controller.
interface ppmc_reg_if;
  logic        wr_stb;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        enable;

  modport master (output wr_stb, output addr, output wdata,
                  input rdata, input enable);
  modport slave  (input wr_stb, input addr, input wdata,
                  output rdata, output enable);
endinterface

// *** core/ppmc_mdio_slave.sv ***
// Serial management interface slave that turns frames into register access.
module ppmc_mdio_slave (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic [4:0]  phy_addr_i,
  ppmc_reg_if.master       bus
);

  logic                     mdc_q_r;
  logic                     rise;
  ppmc_pkg::ppmc_mdio_state_t state_r;
  logic [5:0]               cnt_r;
  logic [15:0]              shreg_r;
  logic [15:0]              data_r;
  logic [4:0]               addr_r;
  logic                     hit_r;
  logic                     wr_r;
  logic [11:0]              hdr;

  // Bits are taken on the rising management clock edge.
  assign rise = mdc_i & ~mdc_q_r;
  assign hdr  = {shreg_r[10:0], mdio_i};

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mdc_i;
    end
  end

  // Frame sequencer; a frame for another address is followed but not served.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r   <= ppmc_pkg::MS_IDLE;
      cnt_r     <= 6'h00;
      shreg_r   <= 16'h0000;
      data_r    <= 16'h0000;
      addr_r    <= 5'h00;
      hit_r     <= 1'b0;
      wr_r      <= 1'b0;
      mdio_o    <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      if (rise) begin
        case (state_r)
          ppmc_pkg::MS_IDLE: begin
            if (mdio_i) begin
              if (cnt_r != ppmc_pkg::PREAMBLE_LEN) begin
                cnt_r <= cnt_r + 6'h01;
              end
            end else begin
              if (cnt_r == ppmc_pkg::PREAMBLE_LEN) begin
                state_r <= ppmc_pkg::MS_START;
              end
              cnt_r <= 6'h00;
            end
          end
          ppmc_pkg::MS_START: begin
            state_r <= mdio_i ? ppmc_pkg::MS_HDR : ppmc_pkg::MS_IDLE;
            cnt_r   <= 6'h00;
          end
          ppmc_pkg::MS_HDR: begin
            shreg_r <= {shreg_r[14:0], mdio_i};
            cnt_r   <= cnt_r + 6'h01;
            if (cnt_r == ppmc_pkg::HDR_LAST) begin
              addr_r <= hdr[4:0];
              hit_r  <= (hdr[9:5] == phy_addr_i) & bus.enable;
              cnt_r  <= 6'h00;
              if (hdr[11:10] == ppmc_pkg::OP_READ) begin
                state_r <= ppmc_pkg::MS_READ;
              end else if (hdr[11:10] == ppmc_pkg::OP_WRITE) begin
                state_r <= ppmc_pkg::MS_WRITE;
              end else begin
                state_r <= ppmc_pkg::MS_IDLE;
              end
            end
          end
          ppmc_pkg::MS_READ: begin
            // Turnaround low first, then sixteen data bits MSB first.
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == 6'h00) begin
              data_r    <= bus.rdata;
              mdio_o    <= 1'b0;
              mdio_oe_o <= hit_r;
            end else if (cnt_r == ppmc_pkg::RD_LAST) begin
              mdio_oe_o <= 1'b0;
              state_r   <= ppmc_pkg::MS_IDLE;
              cnt_r     <= 6'h00;
            end else begin
              mdio_o <= data_r[15];
              data_r <= {data_r[14:0], 1'b0};
            end
          end
          ppmc_pkg::MS_WRITE: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r >= ppmc_pkg::WR_FIRST) begin
              shreg_r <= {shreg_r[14:0], mdio_i};
            end
            if (cnt_r == ppmc_pkg::WR_LAST) begin
              wr_r    <= hit_r;
              state_r <= ppmc_pkg::MS_IDLE;
              cnt_r   <= 6'h00;
            end
          end
          default: begin
            state_r   <= ppmc_pkg::MS_IDLE;
            cnt_r     <= 6'h00;
            mdio_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // Write data is whole in the shift register when the strobe is raised.
  assign bus.wr_stb = wr_r;
  assign bus.addr   = addr_r;
  assign bus.wdata  = shreg_r;

endmodule // ppmc_mdio_slave

// *** testbench/ppmc_monitor.sv ***
// Pin-level checker of the power-mode controller.
module ppmc_monitor #(
  parameter int LP_NORMAL_CYCLES = 20
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic standby_o,
  input wire logic core_func_en_o,
  input wire logic rx_blocks_en_o,
  input wire logic pll_en_o,
  input wire logic io_en_o,
  input wire logic link_pulse_o,
  input wire logic soft_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] gap_r;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles since the last link pulse; saturates so a long quiet never wraps.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i)
      gap_r <= 32'hffffffff;
    else if (link_pulse_o)
      gap_r <= 32'h00000001;
    else if (gap_r != 32'hffffffff)
      gap_r <= gap_r + 32'h00000001;
  end
  property p_sticky; standby_o |=> standby_o; endproperty
  property p_stby_off; standby_o |=> !io_en_o && !core_func_en_o; endproperty
  property p_lp_one; link_pulse_o |=> !link_pulse_o; endproperty
  property p_sr_one; soft_reset_o |=> !soft_reset_o; endproperty
  property p_lp_stby; $past(standby_o, 3) |-> !link_pulse_o; endproperty
  property p_gap; link_pulse_o |-> gap_r >= 32'(LP_NORMAL_CYCLES); endproperty
  property p_chain; !core_func_en_o |-> !rx_blocks_en_o && !pll_en_o;
  endproperty
  property p_io; !io_en_o |-> !core_func_en_o; endproperty
  property p_ta; $rose(mdio_oe_o) |-> !mdio_o ##1 mdio_oe_o[*7]; endproperty
  property p_bit;
    mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o)
      |-> $past(mdc_i) && !$past(mdc_i, 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("standby left");
  a_stby_off: assert property (p_stby_off)
    else $error("alive in standby");
  a_lp_one: assert property (p_lp_one) else $error("long link pulse");
  a_sr_one: assert property (p_sr_one) else $error("long soft reset");
  a_lp_stby: assert property (p_lp_stby)
    else $error("pulse in standby");
  a_gap: assert property (p_gap) else $error("link pulses too close");
  a_chain: assert property (p_chain)
    else $error("block on in powerdown");
  a_io: assert property (p_io) else $error("core on without io");
  a_ta: assert property (p_ta) else $error("bad turnaround");
  a_bit: assert property (p_bit) else $error("data off clock rise");
  c_stby: cover property ($rose(standby_o));
  c_read: cover property ($rose(mdio_oe_o));
  c_sr: cover property (soft_reset_o);
endmodule // ppmc_monitor

bind ppmc_phy_power_mode_control ppmc_monitor #(
  .LP_NORMAL_CYCLES(LP_NORMAL_CYCLES)
) mon_u (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_o(mdio_o),
  .mdio_oe_o(mdio_oe_o), .standby_o(standby_o),
  .core_func_en_o(core_func_en_o), .rx_blocks_en_o(rx_blocks_en_o),
  .pll_en_o(pll_en_o), .io_en_o(io_en_o), .link_pulse_o(link_pulse_o),
  .soft_reset_o(soft_reset_o)
);

// *** testbench/ppmc_mdio_host.sv ***
// Management host model that clocks frames onto the serial pins.
module ppmc_mdio_host (
  input  wire logic clock_i,
  input  wire logic dev_data_i,
  input  wire logic dev_oe_i,
  output logic      mdc_o,
  output logic      mdio_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_r;
  logic bit_r;
  int   half_cyc = 4;
  // A released line is pulled up, so nobody driving reads as one.
  assign mdio_o = dev_oe_i ? dev_data_i : (drv_r ? bit_r : 1'b1);
  initial begin
    mdc_o = 1'b0;
    drv_r = 1'b0;
    bit_r = 1'b0;
  end
  // One management clock; the line level seen at its rise is returned.
  task automatic tick(input logic d, input logic drv, output logic s);
    drv_r <= drv;
    bit_r <= d;
    repeat (half_cyc) @(posedge clock_i);
    s = mdio_o;
    mdc_o <= 1'b1;
    repeat (half_cyc) @(posedge clock_i);
    mdc_o <= 1'b0;
  endtask
  // Full frame with fresh preamble; the clock stands low between frames.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic [17:0] tail;
    logic        s;
    hdr = {2'b01, op, pa, ra};
    tail = {2'b10, wd};
    for (int i = 0; i < 32; i++) tick(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) tick(hdr[i], 1'b1, s);
    for (int i = 17; i >= 0; i--) begin
      tick(tail[i], op == 2'h1, s);
      if (i < 16) rd[i] = s;
    end
    drv_r <= 1'b0;
    // Let one edge pass so a following frame never re-drives in this step.
    @(posedge clock_i);
  endtask
endmodule // ppmc_mdio_host

// *** testbench/ppmc_phy_power_mode_control_bench.sv ***
// Self-checking bench of the power-mode controller.
module ppmc_phy_power_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] PA = 5'h03;
  localparam int LPN = 20;
  localparam int LPE = 60;
  localparam int SH = ppmc_pkg::DEASSERT_SHORT_CYC;
  logic        clock_i, rst_n_i, mdc_i, mdio_i, mdio_o, mdio_oe_o;
  logic        supply, link, ea, eb, ind, stby, core, rx, pll, io, slow;
  logic        lp, sr, tx, ed;
  logic [15:0] q, d;
  logic [4:0]  a;
  int          err_count, checked, seed, sr_cnt, n;
  ppmc_phy_power_mode_control #(.LP_NORMAL_CYCLES(LPN), .LP_ENERGY_IDLE_POWERDOWN_CYCLES(LPE))
  dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .mdc_i(mdc_i), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .phy_addr_i(PA),
    .core_supply_ok_i(supply), .link_up_i(link), .energy_pair_a_i(ea),
    .energy_pair_b_i(eb), .cable_energy_indicator_o(ind), .standby_o(stby),
    .core_func_en_o(core), .rx_blocks_en_o(rx), .pll_en_o(pll), .tx_en_o(tx),
    .energy_det_en_o(ed), .io_en_o(io), .slow_osc_sel_o(slow),
    .link_pulse_o(lp), .soft_reset_o(sr));
  ppmc_mdio_host host_u (.clock_i(clock_i), .dev_data_i(mdio_o),
    .dev_oe_i(mdio_oe_o), .mdc_o(mdc_i), .mdio_o(mdio_i));
  // Free-running 50 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Soft reset pulses are counted, since one can fall between checks.
  always @(posedge clock_i) if (sr === 1'b1) sr_cnt++;
  // Read-back of an implemented register: unused bits read as zero.
  function automatic logic [15:0] rb(input logic [4:0] r,
                                     input logic [15:0] v);
    return r == 5'h14 ? v & ppmc_pkg::STBY_MASK : v & ppmc_pkg::AC2_KEEP_MASK;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic waitc(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  task automatic wr(input logic [4:0] r, input logic [15:0] v);
    host_u.frame(2'h1, PA, r, v, q);
    waitc(3);
  endtask
  task automatic rd(input logic [4:0] r, input logic [15:0] e,
                    input string nm);
    host_u.frame(2'h2, PA, r, 16'h0000, q);
    chk(nm, e, q);
  endtask
  task automatic hw_reset();
    rst_n_i <= 1'b0;
    waitc(5);
    rst_n_i <= 1'b1;
    waitc(2);
  endtask
  // Measures one full spacing between consecutive link pulses.
  task automatic gap(input int e);
    n = 0;
    while (lp !== 1'b1 && n < 500) begin
      waitc(1);
      n++;
    end
    waitc(1);
    n = 1;
    while (lp !== 1'b1 && n < 500) begin
      waitc(1);
      n++;
    end
    chk("lp_gap", 16'(e), 16'(n));
  endtask
  task automatic results();
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog sized well above the expected run of some 28000 cycles.
  initial begin
    waitc(90000);
    err_count++;
    results();
  end
  initial begin
    seed = 28902;
    {link, ea, eb} = 3'h0;
    supply = 1'b1;
    hw_reset();
    chk("ind_rst", 16'h1, 16'(ind));
    chk("rx_rst", 16'h1, 16'(rx));
    rd(5'h18, 16'h0800, "energy_idle_powerdown_rst");
    rd(5'h1f, 16'h0000, "ps_rst");
    wr(5'h1f, 16'h0400);
    chk("ps_rx", 16'h0, 16'(rx));
    chk("ps_pll", 16'h1, 16'(pll));
    chk("ps_tx", 16'h1, 16'(tx));
    chk("ps_ed", 16'h1, 16'(ed));
    link <= 1'b1;
    waitc(4);
    chk("ps_link", 16'h1, 16'(rx));
    rd(5'h01, 16'h0004, "link_stat");
    link <= 1'b0;
    wr(5'h1f, 16'h0000);
    wr(5'h18, 16'h0000);
    chk("energy_idle_powerdown_rx", 16'h0, 16'(rx));
    gap(LPE);
    wr(5'h10, 16'h0010);
    chk("pll_off", 16'h0, 16'(pll));
    wr(5'h18, 16'h0800);
    chk("pll_back", 16'h1, 16'(pll));
    gap(LPN);
    wr(5'h10, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      d = 16'($random(seed)) & 16'hffd7;
      a = i[0] ? 5'h13 : 5'h14;
      wr(a, d);
      host_u.frame(2'h1, PA ^ 5'h01, a, ~d, q);
      rd(a, rb(a, d), "rand_reg");
    end
    wr(5'h00, 16'h0800);
    chk("pd_core", 16'h0, 16'(core));
    chk("pd_tx", 16'h0, 16'(tx));
    chk("pd_ed", 16'h0, 16'(ed));
    rd(5'h13, rb(5'h13, d), "pd_mgmt");
    wr(5'h00, 16'h1000);
    chk("pd_exit", 16'h1, 16'(core));
    wr(5'h11, 16'h0040);
    chk("slow_on", 16'h1, 16'(slow));
    wr(5'h00, 16'h1800);
    wr(5'h11, 16'h0000);
    chk("slow_off", 16'h0, 16'(slow));
    wr(5'h00, 16'h1000);
    n = sr_cnt;
    wr(5'h00, 16'h9000);
    chk("soft_rst", 16'(n + 1), 16'(sr_cnt));
    host_u.half_cyc = 6;
    wr(5'h14, 16'h0011);
    wr(5'h14, 16'h0001);
    rd(5'h14, 16'h0001, "vol14");
    supply <= 1'b0;
    waitc(10);
    supply <= 1'b1;
    waitc(3);
    rd(5'h14, 16'h0011, "kept14");
    wr(5'h14, 16'h0058);
    ea <= 1'b1;
    waitc(4);
    chk("ind_a", 16'h1, 16'(ind));
    ea <= 1'b0;
    waitc(SH - 10);
    chk("ind_hold", 16'h1, 16'(ind));
    waitc(20);
    chk("ind_drop", 16'h0, 16'(ind));
    chk("cpu_wait", 16'h0, 16'(stby));
    eb <= 1'b1;
    waitc(4);
    chk("ind_b", 16'h1, 16'(ind));
    wr(5'h14, 16'h005a);
    eb <= 1'b0;
    waitc(SH + 10);
    chk("ind_long", 16'h1, 16'(ind));
    waitc(ppmc_pkg::DEASSERT_LONG_CYC - SH);
    chk("ind_ldrop", 16'h0, 16'(ind));
    wr(5'h14, 16'h005b);
    chk("ind_pol", 16'h1, 16'(ind));
    wr(5'h14, 16'h007b);
    chk("cpu_stby", 16'h1, 16'(stby));
    chk("stby_io", 16'h0, 16'(io));
    chk("stby_tx", 16'h0, 16'(tx));
    wr(5'h14, 16'h0000);
    chk("stby_stay", 16'h1, 16'(stby));
    hw_reset();
    chk("stby_rst", 16'h0, 16'(stby));
    rd(5'h14, 16'h0000, "rst14");
    wr(5'h14, 16'h0018);
    waitc(SH + 10);
    chk("auto_stby", 16'h1, 16'(stby));
    ea <= 1'b1;
    waitc(4);
    chk("ind_wake", 16'h1, 16'(ind));
    chk("auto_stay", 16'h1, 16'(stby));
    results();
  end
endmodule // ppmc_phy_power_mode_control_bench
